/* File: hdl/dcm_pkg.sv */
// constants, register map and types of the dual channel discrepancy monitor
package dcm_pkg;

  // time base
  localparam int CLK_KHZ       = 10_000;
  localparam int TICK_MS       = 4;
  localparam int TICK_CYCLES   = TICK_MS * CLK_KHZ;
  localparam int LIMIT_MIN_MS  = 4;
  localparam int LIMIT_MAX_MS  = 30_000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_TICKS   = BLINK_HALF_MS / TICK_MS;

  // widths
  localparam int LIM_W = 15;
  localparam int TMR_W = 13;
  localparam int BLK_W = 7;
  localparam int EV_W  = 4;

  // register byte addresses
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_LIMIT    = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_TIMER    = 8'h0c;
  localparam logic [7:0] A_IRQ_STAT = 8'h10;
  localparam logic [7:0] A_IRQ_EN   = 8'h14;
  localparam logic [7:0] A_IRQ_CLR  = 8'h18;

  // reset values
  localparam logic [LIM_W-1:0] LIMIT_RST_MS = 15'h0000;
  localparam logic [EV_W-1:0]  IRQ_EN_RST   = 4'h0;

  // control fields
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_STYLE = 1;

  // status fields
  localparam int STS_STATE = 0;
  localparam int STS_LOGIC = 2;
  localparam int STS_DISC  = 3;
  localparam int STS_SEQ   = 4;
  localparam int STS_HLTH  = 5;
  localparam int STS_CHA   = 6;
  localparam int STS_CHB   = 7;

  // interrupt events
  localparam int EV_DISC  = 0;
  localparam int EV_SEQ   = 1;
  localparam int EV_ACT   = 2;
  localparam int EV_INACT = 3;

  // channel pair classes
  typedef logic [1:0] dcm_cls_t;
  localparam dcm_cls_t CLS_INACT = 2'h0;
  localparam dcm_cls_t CLS_ACT   = 2'h1;
  localparam dcm_cls_t CLS_DISC  = 2'h2;

  typedef enum logic [1:0] {
    ST_INACT,
    ST_DISCR,
    ST_ACTIVE,
    ST_ERROR
  } dcm_state_e;

endpackage

/* File: hdl/dcm_tick.sv */
// sample tick generator: one-cycle pulse every CYCLES clocks
`timescale 1ns/1ps
module dcm_tick #(
  parameter int unsigned CYCLES = 40000
) (
  input  wire logic mclk,
  input  wire logic srst,
  output logic      tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

/* File: hdl/dcm_monitor.sv */
// dual channel discrepancy monitor with apb register access
//
// Notes on behaviour
// RULE_01: equivalent or complementary channel pairing
// RULE_02: limit zero disables, else 4 ms..30 s
// RULE_03: limit rounded up to 4 ms grid
// RULE_04: disagreement under limit: discrepant, input low
// RULE_05: discrepant keeps discrepancy flag unchanged
// RULE_06: timer restarts on discrepancy; limit gives error
// RULE_07: zero limit: timer never runs, no timeout
// RULE_08: active gives input high, no error
// RULE_09: active needs inactive since last active
// RULE_10: active needs no elapsed discrepancy limit
// RULE_11: forbidden re-entry flagged as sequence error; not flagged when a discrepancy error is already set
// RULE_12: health indicator flashes red or red/green
// RULE_13: channel indicators flash green on error
// RULE_14: health status bit low on error
// RULE_15: errors cleared when pair reaches inactive
// RULE_16: configurer sizes limit above test gap
// RULE_17: channels sampled every 4 ms tick
// RULE_18: reset: inactive, timer and errors cleared
// RULE_19: timer counts ticks against rounded limit
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module dcm_monitor
  import dcm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = dcm_pkg::TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chan_a,
  input  wire logic        chan_b,
  output logic             logic_in,
  output logic             module_health_indicator,
  output logic             health_led_red,
  output logic             health_led_green,
  output logic             chan_a_led,
  output logic             chan_b_led,
  output logic             irq
);
  import dcm_pkg::*;

  // classify the sampled pair; equivalent wants a==b, complementary a!=b
  function automatic dcm_cls_t pair_class(input logic cmpl,
                                          input logic a,
                                          input logic b);
    dcm_cls_t c;
    c = CLS_DISC;
    if (!cmpl && !a && !b) c = CLS_INACT;
    else if (!cmpl && a && b) c = CLS_ACT;
    else if (cmpl && !a && b) c = CLS_INACT;
    else if (cmpl && a && !b) c = CLS_ACT;
    return c;
  endfunction

  // cap the limit at its 30 s maximum; values below 4 ms pass unchanged
  function automatic logic [LIM_W-1:0] lim_clamp(input logic [31:0] v);
    logic [LIM_W-1:0] r;
    r = v[LIM_W-1:0];
    if (v > 32'(LIMIT_MAX_MS)) r = LIM_W'(LIMIT_MAX_MS);
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic             tick;
  logic [1:0]       a_sync;
  logic [1:0]       b_sync;
  logic             a_s;
  logic             b_s;
  logic             mode;
  logic             style;
  logic [LIM_W-1:0] lim_ms;
  logic [TMR_W-1:0] lim_ticks;
  logic [EV_W-1:0]  irq_stat;
  logic [EV_W-1:0]  irq_en;
  logic [EV_W-1:0]  clr_mask;
  logic [EV_W-1:0]  ev;
  dcm_state_e       state;
  dcm_state_e       next_state;
  dcm_cls_t         cls;
  dcm_cls_t         prev_cls;
  logic [TMR_W-1:0] timer;
  logic [TMR_W-1:0] next_timer;
  logic             disc_err;
  logic             next_disc;
  logic             seq_err;
  logic             next_seq;
  logic             seen_inact;
  logic             next_seen;
  logic [BLK_W-1:0] blink_cnt;
  logic             blink;
  logic             err;
  logic             acc;
  logic             wr;
  logic [31:0]      rd_val;
  logic             hit;

  //////////////////////////////////////////////////////////////////////////
  // sample tick and channel synchronisers

  dcm_tick #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .mclk (mclk),
    .srst (srst),
    .tick (tick)
  );

  // pins are asynchronous; only the second stage is ever read
  always_ff @(posedge mclk) begin
    if (srst) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
    end else begin
      a_sync <= {a_sync[0], chan_a};
      b_sync <= {b_sync[0], chan_b};
    end
  end

  assign a_s = a_sync[1];
  assign b_s = b_sync[1];
  assign cls = pair_class(mode, a_s, b_s); // RULE_01
  assign err = disc_err | seq_err;

  //////////////////////////////////////////////////////////////////////////
  // apb slave

  assign acc = psel & penable;
  assign wr  = acc & pready & pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == A_CTRL) begin
      rd_val[CTRL_MODE]  = mode;
      rd_val[CTRL_STYLE] = style;
    end else if (paddr == A_LIMIT) begin
      rd_val[LIM_W-1:0] = lim_ms;
    end else if (paddr == A_STATUS) begin
      rd_val[STS_STATE+:2] = state;
      rd_val[STS_LOGIC]    = logic_in;
      rd_val[STS_DISC]     = disc_err;
      rd_val[STS_SEQ]      = seq_err;
      rd_val[STS_HLTH]     = module_health_indicator;
      rd_val[STS_CHA]      = a_s;
      rd_val[STS_CHB]      = b_s;
    end else if (paddr == A_TIMER) begin
      rd_val[TMR_W-1:0] = timer;
    end else if (paddr == A_IRQ_STAT) begin
      rd_val[EV_W-1:0] = irq_stat;
    end else if (paddr == A_IRQ_EN) begin
      rd_val[EV_W-1:0] = irq_en;
    end else if (paddr == A_IRQ_CLR) begin
      rd_val = 32'h0000_0000;
    end else begin
      hit = 1'b0;
    end
  end

  // one wait state: answer is registered, never combinational
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready && !pwrite) begin
        prdata <= rd_val;
      end else if (!acc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode      <= 1'b0;
      style     <= 1'b0;
      lim_ms    <= LIMIT_RST_MS;
      lim_ticks <= TMR_W'((16'(LIMIT_RST_MS) + 16'(TICK_MS - 1))
                          / 16'(TICK_MS));
      irq_en    <= IRQ_EN_RST;
    end else if (wr) begin
      if (paddr == A_CTRL) begin
        mode  <= pwdata[CTRL_MODE];
        style <= pwdata[CTRL_STYLE];
      end else if (paddr == A_LIMIT) begin
        lim_ms    <= lim_clamp(pwdata); // RULE_02
        // round up to whole sample periods
        lim_ticks <= TMR_W'((16'(lim_clamp(pwdata)) + 16'(TICK_MS - 1))
                            / 16'(TICK_MS)); // RULE_03
      end else if (paddr == A_IRQ_EN) begin
        irq_en <= pwdata[EV_W-1:0];
      end
    end
  end

  assign clr_mask = (wr && paddr == A_IRQ_CLR) ? pwdata[EV_W-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////
  // pair evaluation, stepped only on the sample tick

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_disc  = disc_err;
    next_seq   = seq_err;
    next_seen  = seen_inact;
    if (tick) begin // RULE_17
      case (cls)
        CLS_INACT: begin
          next_state = ST_INACT;
          next_timer = '0;
          next_disc  = 1'b0; // RULE_15
          next_seq   = 1'b0; // RULE_15
          next_seen  = 1'b1;
        end
        CLS_ACT: begin
          next_timer = '0;
          if (state == ST_ACTIVE) begin
            next_state = ST_ACTIVE;
          end else if (seen_inact && !disc_err) begin // RULE_09 RULE_10
            next_state = ST_ACTIVE; // RULE_08
            next_seen  = 1'b0;
          end else begin
            next_state = ST_ERROR;
            // a timeout already reported takes precedence
            if (!disc_err) next_seq = 1'b1; // RULE_11
          end
        end
        default: begin
          if (prev_cls != CLS_DISC) begin
            next_timer = '0; // RULE_06
          end else if (lim_ticks != '0 && timer != '1) begin // RULE_07
            next_timer = timer + 1'b1; // RULE_19
          end
          if (state == ST_ERROR) begin
            next_state = ST_ERROR;
          end else if (lim_ticks != '0 && next_timer >= lim_ticks) begin
            next_state = ST_ERROR; // RULE_06
            next_disc  = 1'b1;
          end else begin
            next_state = ST_DISCR; // RULE_04 RULE_05
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state      <= ST_INACT; // RULE_18
      timer      <= '0;
      disc_err   <= 1'b0;
      seq_err    <= 1'b0;
      seen_inact <= 1'b0;
      prev_cls   <= CLS_INACT;
      logic_in   <= 1'b0;
    end else begin
      state      <= next_state;
      timer      <= next_timer;
      disc_err   <= next_disc;
      seq_err    <= next_seq;
      seen_inact <= next_seen;
      if (tick) prev_cls <= cls;
      logic_in   <= (next_state == ST_ACTIVE); // RULE_04 RULE_08
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // indicators

  always_ff @(posedge mclk) begin
    if (srst) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else if (tick) begin
      if (blink_cnt == BLK_W'(BLINK_TICKS - 1)) begin
        blink_cnt <= '0;
        blink     <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      module_health_indicator <= 1'b0;
      health_led_red          <= 1'b0;
      health_led_green        <= 1'b0;
      chan_a_led              <= 1'b0;
      chan_b_led              <= 1'b0;
    end else begin
      module_health_indicator <= ~(next_disc | next_seq); // RULE_14
      health_led_red          <= err & blink; // RULE_12
      health_led_green        <= err ? (style & ~blink) : 1'b1; // RULE_12
      chan_a_led              <= err ? blink : a_s; // RULE_13
      chan_b_led              <= err ? blink : b_s; // RULE_13
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a clear in the same cycle

  assign ev[EV_DISC]  = next_disc & ~disc_err;
  assign ev[EV_SEQ]   = next_seq & ~seq_err;
  assign ev[EV_ACT]   = (next_state == ST_ACTIVE) & (state != ST_ACTIVE);
  assign ev[EV_INACT] = (next_state == ST_INACT) & (state != ST_INACT);

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr_mask) | ev;
      irq      <= |(((irq_stat & ~clr_mask) | ev) & irq_en);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_INACT_CLEARS: assert property ( // RULE_15
    (tick && cls == CLS_INACT) |=>
      (state == ST_INACT && !disc_err && !seq_err && !logic_in))
    else $error("inactive pair did not clear errors");

  AST_DISCR_LOW: assert property ( // RULE_04
    (state == ST_DISCR) |-> (!logic_in && !disc_err))
    else $error("discrepant state with input high or error");

  AST_DISC_HOLD: assert property ( // RULE_05
    (state == ST_DISCR && $past(state) == ST_DISCR) |-> $stable(disc_err))
    else $error("discrepancy flag moved while discrepant");

  AST_RESTART: assert property ( // RULE_06
    (tick && cls == CLS_DISC && prev_cls != CLS_DISC) |=> (timer == '0))
    else $error("timer not restarted on new discrepancy");

  AST_TIMEOUT: assert property ( // RULE_06
    (tick && cls == CLS_DISC && prev_cls == CLS_DISC && state == ST_DISCR
     && lim_ticks != '0 && timer + 1'b1 >= lim_ticks)
    |=> (state == ST_ERROR && disc_err) ##1 !logic_in)
    else $error("timeout did not raise discrepancy error");

  AST_ZERO_LIMIT: assert property ( // RULE_07
    (lim_ticks == '0 && tick) |=> !$rose(disc_err))
    else $error("timeout raised with monitoring disabled");

  // logic_in is registered from next_state, so it tracks state in step
  AST_ACTIVE_OUT: assert property ( // RULE_08
    (state == ST_ACTIVE) |-> (!disc_err && !seq_err && logic_in))
    else $error("active state without high input");

  AST_SEQ_REFUSE: assert property ( // RULE_09
    (tick && cls == CLS_ACT && state != ST_ACTIVE && !seen_inact)
    |=> (state != ST_ACTIVE)[*2])
    else $error("active entered without passing inactive");

  AST_LIM_REFUSE: assert property ( // RULE_10
    (tick && cls == CLS_ACT && disc_err) |=> (state != ST_ACTIVE))
    else $error("active entered after discrepancy timeout");

  AST_SEQ_FLAG: assert property ( // RULE_11
    (tick && cls == CLS_ACT && state != ST_ACTIVE && !seen_inact
     && !disc_err) |=> seq_err ##1 !module_health_indicator)
    else $error("sequence error not flagged");

  AST_HEALTH_LED: assert property ( // RULE_12
    $past(err) |-> (health_led_red == $past(blink)))
    else $error("health indicator not flashing on error");

  AST_CHAN_LED: assert property ( // RULE_13
    $past(err) |-> (chan_a_led == $past(blink) && chan_b_led == chan_a_led))
    else $error("channel indicators not flashing on error");

  AST_HEALTH_BIT: assert property ( // RULE_14
    err |-> !module_health_indicator)
    else $error("health status high during error");

  AST_LIM_RANGE: assert property ( // RULE_02 RULE_03
    (lim_ms <= LIM_W'(LIMIT_MAX_MS))
    && (16'(lim_ticks) * 16'(TICK_MS) >= 16'(lim_ms))
    && (16'(lim_ticks) * 16'(TICK_MS) < 16'(lim_ms) + 16'(TICK_MS)))
    else $error("limit out of range or badly rounded");

  AST_TICK_ONLY: assert property ( // RULE_17
    (!tick) |=> $stable(state))
    else $error("state changed off the sample tick");

  AST_RESET_STATE: assert property ( // RULE_18
    $past(srst) |-> (state == ST_INACT && timer == '0 && !err))
    else $error("bad state after reset");

  CV_ACTIVE: cover property ($rose(state == ST_ACTIVE));
  CV_TIMEOUT: cover property ($rose(disc_err));
  CV_SEQ: cover property ($rose(seq_err));
  CV_RECOVER: cover property (err ##1 (state == ST_INACT && !err));

endmodule

/* File: bench/dcm_pair_model.sv */
// two-channel contact pair model: channel b trails channel a by lag cycles
`timescale 1ns/1ps
module dcm_pair_model (
  input  wire logic        mclk,
  input  wire logic        tgt,
  input  wire logic        mode,
  input  wire logic [15:0] lag,
  output logic             chan_a,
  output logic             chan_b
);
  logic        a_on = 1'b0;
  logic        b_on = 1'b0;
  logic [15:0] cnt  = 16'h0000;
  // a lag of 16'hffff leaves channel b stuck, as a welded contact would
  always @(posedge mclk) begin
    if (tgt !== a_on) begin
      a_on <= tgt;
      cnt  <= lag;
      if (lag == 16'h0000) begin
        b_on <= tgt;
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
      if (cnt == 16'h0001) begin
        b_on <= a_on;
      end
    end
  end
  assign chan_a = a_on;
  assign chan_b = mode ? ~b_on : b_on;
endmodule

/* File: bench/test_dual_channel_discrepancy_monitor.sv */
// self-checking bench of the dual channel discrepancy monitor
`timescale 1ns/1ps
module test_dual_channel_discrepancy_monitor;
  import dcm_pkg::*;
  localparam int TCK = 8;
  typedef struct packed {
    logic        mode;
    logic [14:0] lim;
    logic [15:0] lag;
    logic [5:0]  sts;
  } dcm_row_s;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        tgt = 1'b0;
  logic        mode = 1'b0;
  logic [15:0] lag = 16'h0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chan_a;
  logic        chan_b;
  logic        logic_in;
  logic        module_health_indicator;
  logic        health_led_red;
  logic        health_led_green;
  logic        chan_a_led;
  logic        chan_b_led;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic        pr;
  logic        pa;
  int          n_fail = 0;
  int          total_checks = 0;
  int          nr;
  int          na;
  int          ng;
  int          nb;
  // state, logic_in, disc, seq, health packed as status bits 5:0
  dcm_row_s rows [9] = '{
    '{1'b0, 15'h0008, 16'h0000, 6'h26},
    '{1'b1, 15'h0008, 16'h0000, 6'h26},
    '{1'b0, 15'h0008, 16'hffff, 6'h0b},
    '{1'b1, 15'h0008, 16'hffff, 6'h0b},
    '{1'b0, 15'h0000, 16'hffff, 6'h21},
    '{1'b0, 15'h0004, 16'h0010, 6'h0b},
    '{1'b0, 15'h0005, 16'h0010, 6'h26},
    '{1'b1, 15'h0009, 16'h0018, 6'h26},
    '{1'b0, 15'h0008, 16'h0018, 6'h0b}};

  always #50 mclk = ~mclk;

  dcm_monitor #(.TICK_CYCLES_P(TCK)) u_dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_a(chan_a), .chan_b(chan_b),
    .logic_in(logic_in), .module_health_indicator(module_health_indicator),
    .health_led_red(health_led_red), .health_led_green(health_led_green),
    .chan_a_led(chan_a_led), .chan_b_led(chan_b_led), .irq(irq));

  dcm_pair_model u_pair (
    .mclk(mclk), .tgt(tgt), .mode(mode), .lag(lag),
    .chan_a(chan_a), .chan_b(chan_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the leading edge keeps two transfers from touching psel in one step
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic sts(input logic [5:0] exp);
    apb(1'b0, A_STATUS, 32'h0);
    chk({26'h0, rd[5:0]}, {26'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    results();
  end

  initial begin
    cyc(6);
    srst <= 1'b0;
    sts(6'h20);
    apb(1'b0, A_LIMIT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, A_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 9; i++) begin
      mode <= rows[i].mode;
      lag <= rows[i].lag;
      apb(1'b1, A_CTRL, {31'h0, rows[i].mode});
      apb(1'b1, A_LIMIT, {17'h0, rows[i].lim});
      cyc(48);
      tgt <= 1'b1;
      cyc(100);
      sts(rows[i].sts);
      chk({31'h0, logic_in}, {31'h0, rows[i].sts[2]});
      chk({31'h0, module_health_indicator}, {31'h0, rows[i].sts[5]});
      tgt <= 1'b0;
      cyc(64);
      sts(6'h20);
    end
    apb(1'b1, A_LIMIT, 32'h7fff);
    apb(1'b0, A_LIMIT, 32'h0);
    chk(rd, 32'h7530);
    apb(1'b1, A_LIMIT, 32'h0);
    lag <= 16'h0000;
    tgt <= 1'b1;
    cyc(60);
    lag <= 16'hffff;
    tgt <= 1'b0;
    cyc(40);
    sts(6'h21);
    apb(1'b0, A_TIMER, 32'h0);
    chk(rd, 32'h0);
    tgt <= 1'b1;
    cyc(40);
    sts(6'h13);
    apb(1'b0, A_IRQ_STAT, 32'h0);
    chk({28'h0, rd[3:0]}, 32'hf);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_IRQ_EN, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_IRQ_CLR, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    // half blink period is 125 ticks, so 2200 clocks hold two toggles
    pr = health_led_red;
    pa = chan_a_led;
    nr = 0;
    na = 0;
    ng = 0;
    nb = 0;
    repeat (2200) begin
      @(posedge mclk);
      nr += int'(health_led_red !== pr);
      nb += int'(chan_b_led !== chan_a_led);
      na += int'(chan_a_led !== pa);
      ng += int'(health_led_green !== 1'b0);
      pr = health_led_red;
      pa = chan_a_led;
    end
    chk({31'h0, nr >= 2}, 32'h1);
    chk({31'h0, na >= 2}, 32'h1);
    chk(nb, 32'h0);
    chk(ng, 32'h0);
    apb(1'b1, A_CTRL, 32'h2);
    cyc(4);
    ng = 0;
    repeat (1100) begin
      @(posedge mclk);
      ng += int'(health_led_green !== ~health_led_red);
    end
    chk(ng, 32'h0);
    lag <= 16'h0000;
    tgt <= 1'b0;
    cyc(40);
    sts(6'h20);
    tgt <= 1'b1;
    cyc(40);
    sts(6'h26);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    sts(6'h20);
    chk({31'h0, logic_in}, 32'h0);
    results();
  end
endmodule
